// >>> src/i2c_slave_flags_status.v
// i2c slave event flags, bus status and slave byte engine
// Summary of operation
// - byte done sets data ready flag
// - data write, smart mode data read or command clears data ready
// - write one clears a flag, zero ignored
// - valid received address sets address match
// - command two or three write clears address match
// - clearing address match sends chosen ack, except by wait command
// - stop sets flag if ours or group
// - command after next match clears stop flag
// - sync busy bit spans domain sync
// - clock hold reads one while stretching
// - hold ends when causing flag clears
// - writing hold bit releases scl
// - scl low timeout sets, several clears
// - repeated start bit on address match
// - direction holds last address r/w bit
// - received nack records master answer
// - collision sets bit, releases lines, waits
// - collision no interrupt, cleared like errors
// - illegal start or stop sets bus error
// - timeout inside frame is bus error
// - bus error clears on ack or write one
// - command three performs acknowledge action
// - smart mode acks on data read
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "i2c_slave_flags_regs.vh"
module i2c_slave_flags_status #(
   parameter TOUT_W = 23,
   parameter [TOUT_W-1:0] TOUT_CYCLES = `SCL_LOW_TOUT_US * `REF_CLK_MHZ
) (
   input wire ref_clk, // 250 MHz core clock
   input wire reset, // sync reset, high
   input wire [7:0] addr, // register byte address
   input wire [15:0] wdata, // write data
   input wire wr_stb, // write strobe
   input wire rd_stb, // read strobe
   output wire [15:0] rdata, // read data, next cycle
   input wire scl_in, // scl pin level
   output wire scl_out, // scl drive value
   output wire scl_oe, // scl pull low enable
   input wire sda_in, // sda pin level
   output wire sda_out, // sda drive value
   output wire sda_oe, // sda pull low enable
   output wire irq // interrupt request
);
   // ************************************************
   // states
   // ************************************************
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ADDR = 4'h1;
   localparam [3:0] S_AHOLD = 4'h2;
   localparam [3:0] S_ACK = 4'h3;
   localparam [3:0] S_RX = 4'h4;
   localparam [3:0] S_DHOLD = 4'h5;
   localparam [3:0] S_TX = 4'h6;
   localparam [3:0] S_TACK = 4'h7;
   localparam [3:0] S_WAIT = 4'h8;

   // ************************************************
   // declarations
   // ************************************************
   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;
   reg [3:0] state_q;
   reg [3:0] bitcnt_q;
   reg [7:0] shift_q;
   reg [7:0] data_q;
   reg [7:0] tx_q;
   reg [6:0] own_addr_q;
   reg ack_act_q;
   reg smart_q;
   reg gcmd_q;
   reg tout_en_q;
   reg [2:0] inten_q;
   reg [2:0] flg_q;
   reg scl_low_timeout_q;
   reg sr_q;
   reg dir_q;
   reg received_not_ack_q;
   reg transmit_collision_q;
   reg bus_error_flag_q;
   reg busy_q;
   reg rep_q;
   reg intxn_q;
   reg nack_q;
   reg release_q;
   reg scl_oe_q;
   reg sda_oe_q;
   reg [1:0] sync_cnt_q;
   reg [TOUT_W-1:0] tout_cnt_q;
   reg [15:0] rdata_q;
   reg irq_q;
   reg [15:0] rd_d;

   // ************************************************
   // pin synchronisation and bus conditions
   // ************************************************
   pin_sync #(
      .W(2)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_in({scl_in, sda_in}),
      .pin_s({scl_s, sda_s})
   );

   bus_cond_detect u_cond (
      .ref_clk(ref_clk),
      .reset(reset),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_cond(start_cond),
      .stop_cond(stop_cond)
   );

   // ************************************************
   // register decode
   // ************************************************
   wire wr_ctrl = wr_stb && (addr == `OFS_CTRL);
   wire wr_flags = wr_stb && (addr == `OFS_FLAGS);
   wire wr_stat = wr_stb && (addr == `OFS_STATUS);
   wire wr_data = wr_stb && (addr == `OFS_DATA);
   wire rd_data = rd_stb && (addr == `OFS_DATA);
   wire [1:0] cmd = wdata[`CTL_CMD_MSB:`CTL_CMD_LSB];
   wire cmd_wr = wr_ctrl && cmd[1];
   wire cmd_ack = wr_ctrl && (cmd == `CMD_ACK);
   wire cmd_wait = wr_ctrl && (cmd == `CMD_WAIT);
   wire smart_rd = rd_data && smart_q;
   wire address_match_flag = flg_q[`FLG_ADDRESS_MATCH_FLAG];
   wire data_ready_flag = flg_q[`FLG_DATA_READY_FLAG];

   wire am_clr = (wr_flags && wdata[`FLG_ADDRESS_MATCH_FLAG]) || cmd_wr;
   wire dr_clr = (wr_flags && wdata[`FLG_DATA_READY_FLAG]) || wr_data ||
                 smart_rd || cmd_wr;
   wire pr_clr = (wr_flags && wdata[`FLG_STOP_RECEIVED_FLAG]) || (cmd_wr && address_match_flag);
   wire err_auto = address_match_flag && am_clr;
   // a start or stop may only ride on the first scl rise of a byte
   wire mid_byte = ((state_q == S_ADDR) || (state_q == S_RX) ||
                    (state_q == S_TX)) && (bitcnt_q > 4'h1);
   wire tout_hit = tout_en_q && busy_q && !scl_s &&
                   (tout_cnt_q == TOUT_CYCLES);

   // ************************************************
   // control registers
   // ************************************************
   always @(posedge ref_clk) begin
      if (reset) begin
         ack_act_q <= 1'b0;
         smart_q <= 1'b0;
         gcmd_q <= 1'b0;
         tout_en_q <= 1'b0;
         inten_q <= `INTEN_RST;
         own_addr_q <= `ADDR_RST;
         sync_cnt_q <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            ack_act_q <= wdata[`CTL_ACKACT];
            smart_q <= wdata[`CTL_SMART];
            gcmd_q <= wdata[`CTL_GCMD];
            tout_en_q <= wdata[`CTL_TOUTEN];
         end
         if (wr_stb && (addr == `OFS_INTENSET))
            inten_q <= inten_q | wdata[2:0];
         if (wr_stb && (addr == `OFS_INTENCLR))
            inten_q <= inten_q & ~wdata[2:0];
         if (wr_stb && (addr == `OFS_ADDR))
            own_addr_q <= wdata[7:1];
         if (wr_ctrl)
            sync_cnt_q <= `SYNC_CYCLES;
         else if (sync_cnt_q != 2'h0)
            sync_cnt_q <= sync_cnt_q - 2'h1;
      end
   end

   // ************************************************
   // scl low timeout counter
   // ************************************************
   always @(posedge ref_clk) begin
      if (reset || scl_s || !busy_q || tout_hit)
         tout_cnt_q <= {TOUT_W{1'b0}};
      else
         tout_cnt_q <= tout_cnt_q + {{(TOUT_W-1){1'b0}}, 1'b1};
   end

   // ************************************************
   // clock stretching
   // ************************************************
   always @(posedge ref_clk) begin
      if (reset) begin
         release_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else begin
         if (wr_stat && scl_oe_q)
            release_q <= 1'b1;
         else if (tout_hit || transmit_collision_q)
            release_q <= 1'b1;
         else if (!address_match_flag && !data_ready_flag)
            release_q <= 1'b0;
         // pull only once scl is already low
         scl_oe_q <= (address_match_flag || data_ready_flag) && !release_q && busy_q &&
                     !(wr_stat && scl_oe_q) && (scl_oe_q || !scl_s);
      end
   end

   // ************************************************
   // slave engine, flags and status
   // ************************************************
   always @(posedge ref_clk) begin
      if (reset) begin
         state_q <= S_IDLE;
         bitcnt_q <= 4'h0;
         shift_q <= `DATA_RST;
         data_q <= `DATA_RST;
         tx_q <= `DATA_RST;
         flg_q <= `FLAGS_RST;
         scl_low_timeout_q <= `STAT_BIT_RST;
         sr_q <= `STAT_BIT_RST;
         dir_q <= `STAT_BIT_RST;
         received_not_ack_q <= `STAT_BIT_RST;
         transmit_collision_q <= `STAT_BIT_RST;
         bus_error_flag_q <= `STAT_BIT_RST;
         busy_q <= 1'b0;
         rep_q <= 1'b0;
         intxn_q <= 1'b0;
         nack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         // write one clears, hardware clears too
         if (dr_clr)
            flg_q[`FLG_DATA_READY_FLAG] <= 1'b0;
         if (am_clr)
            flg_q[`FLG_ADDRESS_MATCH_FLAG] <= 1'b0;
         if (pr_clr)
            flg_q[`FLG_STOP_RECEIVED_FLAG] <= 1'b0;
         if ((wr_stat && wdata[`ST_SCL_LOW_TIMEOUT]) || err_auto)
            scl_low_timeout_q <= 1'b0;
         if ((wr_stat && wdata[`ST_TRANSMIT_COLLISION]) || err_auto)
            transmit_collision_q <= 1'b0;
         if ((wr_stat && wdata[`ST_BUS_ERROR_FLAG]) || err_auto)
            bus_error_flag_q <= 1'b0;
         if (wr_data)
            data_q <= wdata[7:0];
         case (state_q)
            S_ADDR: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (bitcnt_q == 4'h7) begin
                     bitcnt_q <= 4'h0;
                     if (shift_q[6:0] == own_addr_q) begin
                        flg_q[`FLG_ADDRESS_MATCH_FLAG] <= 1'b1;
                        dir_q <= sda_s;
                        sr_q <= rep_q;
                        intxn_q <= 1'b1;
                        state_q <= S_AHOLD;
                     end else begin
                        state_q <= S_WAIT;
                     end
                  end
               end
            end
            S_AHOLD: begin
               // command three acts here too
               // wait command gives up without touching sda
               if (cmd_wait)
                  state_q <= S_WAIT;
               else if (am_clr) begin
                  nack_q <= ack_act_q;
                  sda_oe_q <= !ack_act_q;
                  bitcnt_q <= 4'h0;
                  state_q <= S_ACK;
               end
            end
            S_ACK: begin
               if (scl_rise) begin
                  bitcnt_q <= 4'h1;
                  if (nack_q && !sda_s) begin
                     transmit_collision_q <= 1'b1;
                     sda_oe_q <= 1'b0;
                     state_q <= S_WAIT;
                  end
               end else if (scl_fall && (bitcnt_q == 4'h1)) begin
                  sda_oe_q <= 1'b0;
                  bitcnt_q <= 4'h0;
                  if (nack_q)
                     state_q <= S_WAIT;
                  else if (dir_q) begin
                     flg_q[`FLG_DATA_READY_FLAG] <= 1'b1;
                     state_q <= S_DHOLD;
                  end else
                     state_q <= S_RX;
               end
            end
            S_RX: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (bitcnt_q == 4'h7) begin
                     data_q <= {shift_q[6:0], sda_s};
                     flg_q[`FLG_DATA_READY_FLAG] <= 1'b1;
                     bitcnt_q <= 4'h0;
                     state_q <= S_DHOLD;
                  end
               end
            end
            S_DHOLD: begin
               if (cmd_wait)
                  state_q <= S_WAIT;
               else if (dir_q && (wr_data || cmd_ack)) begin
                  tx_q <= wr_data ? wdata[7:0] : data_q;
                  sda_oe_q <= wr_data ? !wdata[7] : !data_q[7];
                  bitcnt_q <= 4'h0;
                  state_q <= S_TX;
               end else if (!dir_q && data_ready_flag && dr_clr) begin
                  nack_q <= ack_act_q;
                  sda_oe_q <= !ack_act_q;
                  bitcnt_q <= 4'h0;
                  state_q <= S_ACK;
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (tx_q[7] && !sda_s) begin
                     transmit_collision_q <= 1'b1;
                     sda_oe_q <= 1'b0;
                     state_q <= S_WAIT;
                  end
               end else if (scl_fall) begin
                  if (bitcnt_q == 4'h8) begin
                     sda_oe_q <= 1'b0;
                     state_q <= S_TACK;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sda_oe_q <= !tx_q[6];
                  end
               end
            end
            S_TACK: begin
               if (scl_rise) begin
                  received_not_ack_q <= sda_s;
                  bitcnt_q <= 4'h0;
                  if (sda_s)
                     state_q <= S_WAIT;
                  else begin
                     flg_q[`FLG_DATA_READY_FLAG] <= 1'b1;
                     state_q <= S_DHOLD;
                  end
               end
            end
            S_IDLE, S_WAIT: begin
               sda_oe_q <= 1'b0;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
         if (tout_hit) begin
            scl_low_timeout_q <= 1'b1;
            bus_error_flag_q <= 1'b1;
            sda_oe_q <= 1'b0;
            state_q <= S_WAIT;
         end
         if (start_cond) begin
            if (mid_byte)
               bus_error_flag_q <= 1'b1;
            rep_q <= busy_q;
            busy_q <= 1'b1;
            bitcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            state_q <= S_ADDR;
         end
         if (stop_cond) begin
            // stop inside byte or right after start
            if (mid_byte || ((state_q == S_ADDR) && (bitcnt_q <= 4'h1)))
               bus_error_flag_q <= 1'b1;
            // only our transaction or group mode
            if (intxn_q || gcmd_q)
               flg_q[`FLG_STOP_RECEIVED_FLAG] <= 1'b1;
            busy_q <= 1'b0;
            intxn_q <= 1'b0;
            rep_q <= 1'b0;
            bitcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            state_q <= S_IDLE;
         end
      end
   end

   // ************************************************
   // read path and interrupt
   // ************************************************
   // read mux, unmapped reads give zero
   always @* begin
      rd_d = 16'h0000;
      case (addr)
         `OFS_CTRL:
            rd_d = {10'h000, tout_en_q, gcmd_q, smart_q, ack_act_q,
                    2'h0};
         `OFS_INTENCLR, `OFS_INTENSET:
            rd_d = {13'h0000, inten_q};
         `OFS_FLAGS:
            rd_d = {13'h0000, flg_q};
         `OFS_STATUS:
            rd_d = {(sync_cnt_q != 2'h0), 7'h00, scl_oe_q, scl_low_timeout_q,
                    1'b0, sr_q, dir_q, received_not_ack_q, transmit_collision_q, bus_error_flag_q};
         `OFS_ADDR:
            rd_d = {8'h00, own_addr_q, 1'b0};
         `OFS_DATA:
            rd_d = {8'h00, data_q};
         default:
            rd_d = 16'h0000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= 16'h0000;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rd_stb ? rd_d : 16'h0000;
         irq_q <= |(flg_q & inten_q);
      end
   end

   assign rdata = rdata_q;
   assign irq = irq_q;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;
endmodule

// >>> src/i2c_slave_flags_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef I2C_SLAVE_FLAGS_REGS_VH
`define I2C_SLAVE_FLAGS_REGS_VH
// ************************************************
// register byte offsets
// ************************************************
`define OFS_CTRL 8'h04
`define OFS_INTENCLR 8'h0C
`define OFS_INTENSET 8'h0D
`define OFS_FLAGS 8'h0E
`define OFS_STATUS 8'h10
`define OFS_ADDR 8'h14
`define OFS_DATA 8'h18
// ************************************************
// event flag positions
// ************************************************
`define FLG_DATA_READY_FLAG 2
`define FLG_ADDRESS_MATCH_FLAG 1
`define FLG_STOP_RECEIVED_FLAG 0
// ************************************************
// status positions
// ************************************************
`define ST_SYNC 15
`define ST_HOLD 7
`define ST_SCL_LOW_TIMEOUT 6
`define ST_SR 4
`define ST_DIR 3
`define ST_RECEIVED_NOT_ACK 2
`define ST_TRANSMIT_COLLISION 1
`define ST_BUS_ERROR_FLAG 0
// ************************************************
// control positions and commands
// ************************************************
`define CTL_CMD_MSB 1
`define CTL_CMD_LSB 0
`define CTL_ACKACT 2
`define CTL_SMART 3
`define CTL_GCMD 4
`define CTL_TOUTEN 5
`define CMD_WAIT 2'h2
`define CMD_ACK 2'h3
// ************************************************
// reset values
// ************************************************
`define FLAGS_RST 3'h0
`define INTEN_RST 3'h0
`define STAT_BIT_RST 1'b0
`define ADDR_RST 7'h00
`define DATA_RST 8'h00
// ************************************************
// timing
// ************************************************
`define REF_CLK_MHZ 250
`define SCL_LOW_TOUT_US 25
`define SYNC_CYCLES 2'h3
`endif

// >>> src/pin_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter W = 2
) (
   input wire ref_clk, // core clock
   input wire reset, // sync reset, high
   input wire [W-1:0] pin_in, // raw pin levels
   output wire [W-1:0] pin_s // synchronised levels
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // idle bus is high, so reset to ones
   always @(posedge ref_clk) begin
      if (reset) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign pin_s = sync_q;
endmodule

// >>> src/bus_cond_detect.v
// scl edge and start/stop condition detector
`timescale 1ns/1ps
module bus_cond_detect (
   input wire ref_clk, // core clock
   input wire reset, // sync reset, high
   input wire scl_s, // synchronised scl
   input wire sda_s, // synchronised sda
   output wire scl_rise, // scl rising, one cycle
   output wire scl_fall, // scl falling, one cycle
   output wire start_cond, // start seen, one cycle
   output wire stop_cond // stop seen, one cycle
);
   reg scl_q;
   reg sda_q;

   // previous line levels
   always @(posedge ref_clk) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // sda moving while scl stays high marks a condition
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
endmodule

// >>> sim/i2c_slave_flags_checker.sv
// port-level assertions for the i2c slave flags and status block
`timescale 1ns/1ps
`include "i2c_slave_flags_regs.vh"
module i2c_slave_flags_checker (
   input wire ref_clk, // core clock
   input wire reset, // sync reset, high
   input wire [7:0] addr, // register address
   input wire [15:0] wdata, // write data
   input wire wr_stb, // write strobe
   input wire rd_stb, // read strobe
   input wire [15:0] rdata, // read data
   input wire scl_in, // scl wire
   input wire scl_out, // scl value
   input wire scl_oe, // scl pull low
   input wire sda_in, // sda wire
   input wire sda_out, // sda value
   input wire sda_oe, // sda pull low
   input wire irq // interrupt
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // decode of the mapped offsets
   wire hit = addr == `OFS_CTRL || addr == `OFS_INTENCLR ||
      addr == `OFS_INTENSET || addr == `OFS_FLAGS ||
      addr == `OFS_STATUS || addr == `OFS_ADDR || addr == `OFS_DATA;
   // clears that must end a stretch
   wire clr = (addr == `OFS_FLAGS && wdata[1]) ||
      (addr == `OFS_CTRL && wdata[1:0] == `CMD_ACK);
   a_read_idle: assert property (
      !$past(rd_stb) |-> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (
      rd_stb && !hit |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_cmd_reads_zero: assert property (
      rd_stb && addr == `OFS_CTRL |=> rdata[1:0] == 2'h0)
      else $error("command field reads back");
   a_status_spare: assert property (
      rd_stb && addr == `OFS_STATUS |=> rdata[14:8] == 7'h00 && !rdata[5])
      else $error("spare status bits set");
   a_hold_mirror: assert property (
      rd_stb && addr == `OFS_STATUS |=> rdata[7] == $past(scl_oe))
      else $error("hold bit differs from scl stretch");
   a_sync_window: assert property (
      rd_stb && addr == `OFS_STATUS && $past(wr_stb && addr == `OFS_CTRL, 2)
      |=> rdata[15])
      else $error("sync busy not seen after control write");
   a_hold_release: assert property (
      wr_stb && addr == `OFS_STATUS && scl_oe |-> ##[1:2] !scl_oe)
      else $error("status write did not release scl");
   a_clear_release: assert property (
      wr_stb && clr && scl_oe |-> ##[1:2] !scl_oe)
      else $error("flag clear did not release scl");
   a_reset_quiet: assert property (
      $fell(reset) |-> !scl_oe && !sda_oe && !irq)
      else $error("lines or irq active after reset");
   a_lines_open: assert property (!scl_out && !sda_out)
      else $error("open drain value not zero");
   c_stretch: cover property ($rose(scl_oe));
   c_ack: cover property ($rose(sda_oe));
   c_irq: cover property ($rose(irq));
endmodule
bind i2c_slave_flags_status i2c_slave_flags_checker chk_i (
   .ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// >>> sim/i2c_master_model.sv
// behavioural i2c bus master, 80 ns scl when not stretched
`timescale 1ns/1ps
module i2c_master_model (
   input wire scl_w, // scl wire level
   input wire sda_w, // sda wire level
   output logic scl_m, // scl, high releases
   output logic sda_m, // sda, high releases
   output logic stuck // stretch wait ran out
);
   // lines released at power up
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
      stuck = 1'b0;
   end
   // one bit: drive, release scl, honour stretch, sample
   task automatic pulse(input logic b, output logic r);
      int i;
      sda_m = b;
      #20 scl_m = 1'b1;
      for (i = 0; i < 300 && scl_w !== 1'b1; i++) #10;
      if (scl_w !== 1'b1) stuck = 1'b1;
      #40 r = sda_w;
      scl_m = 1'b0;
      #20;
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic ack,
      output logic [7:0] q, output logic a);
      int k;
      for (k = 7; k >= 0; k--) pulse(d[k], q[k]);
      pulse(ack, a);
   endtask
   task automatic start;
      sda_m = 1'b1;
      #20 scl_m = 1'b1;
      #20 sda_m = 1'b0;
      #20 scl_m = 1'b0;
      #20;
   endtask
   task automatic stop;
      sda_m = 1'b0;
      #20 scl_m = 1'b1;
      #20 sda_m = 1'b1;
      #40;
   endtask
endmodule

// >>> sim/i2c_slave_flags_status_test.sv
// self-checking bench for the i2c slave flags and status block
`timescale 1ns/1ps
`include "i2c_slave_flags_regs.vh"
module i2c_slave_flags_status_test;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   wire [15:0] rdata;
   wire scl_out, scl_oe, sda_out, sda_oe, irq, scl_m, sda_m, stuck;
   wire scl_w = scl_m & ~scl_oe;
   wire sda_w = sda_m & ~sda_oe;
   int error_cnt = 0;
   int n_tests = 0;
   logic [7:0] q;
   logic a;
   // 250 MHz core clock
   always #2 ref_clk = ~ref_clk;
   i2c_slave_flags_status i2c_slave_flags_status_i (.ref_clk(ref_clk),
      .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq(irq));
   i2c_master_model mst_i (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
      .sda_m(sda_m), .stuck(stuck));
   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         $display("BAD %s exp %h got %h", n, e, s);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a_i, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a_i;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a_i, input logic [15:0] e,
      input logic [15:0] m = 16'hffff);
      @(posedge ref_clk);
      addr <= a_i;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 chk($sformatf("reg %h", a_i), e, rdata & m);
   endtask
   // bounded wait for the slave to stretch scl
   task automatic wait_oe;
      int i;
      for (i = 0; i < 2000 && scl_oe !== 1'b1; i++) @(posedge ref_clk);
      if (scl_oe !== 1'b1) begin
         chk("scl hold", 16'h0001, {15'h0000, scl_oe});
         summarize();
      end
   endtask
   // hang guard
   initial begin
      #300000 error_cnt++;
      summarize();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(`OFS_FLAGS, 16'h0000);
      rd(`OFS_STATUS, 16'h0000);
      rd(8'h08, 16'h0000);
      wr(`OFS_ADDR, 16'h00a4);
      wr(`OFS_CTRL, 16'h0008);
      rd(`OFS_STATUS, 16'h8000);
      // master write of one byte
      fork
         begin
            mst_i.start();
            mst_i.xfer(8'ha4, 1'b1, q, a);
         end
         begin
            wait_oe();
            rd(`OFS_FLAGS, 16'h0002);
            rd(`OFS_STATUS, 16'h0080);
            wr(`OFS_FLAGS, 16'h0000);
            rd(`OFS_FLAGS, 16'h0002);
            wr(`OFS_FLAGS, 16'h0002);
            rd(`OFS_STATUS, 16'h0000);
         end
      join
      chk("address ack", 16'h0000, {15'h0000, a});
      fork
         mst_i.xfer(8'h96, 1'b1, q, a);
         begin
            wait_oe();
            rd(`OFS_FLAGS, 16'h0004);
            rd(`OFS_DATA, 16'h0096);
            rd(`OFS_FLAGS, 16'h0000);
         end
      join
      chk("data ack", 16'h0000, {15'h0000, a});
      mst_i.stop();
      repeat (8) @(posedge ref_clk);
      rd(`OFS_FLAGS, 16'h0001);
      wr(`OFS_INTENSET, 16'h0001);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", 16'h0001, {15'h0000, irq});
      // master read, nack from the master
      fork
         begin
            mst_i.start();
            mst_i.xfer(8'ha5, 1'b1, q, a);
         end
         begin
            wait_oe();
            rd(`OFS_STATUS, 16'h0088);
            wr(`OFS_CTRL, 16'h000b);
            rd(`OFS_FLAGS, 16'h0000);
            chk("irq", 16'h0000, {15'h0000, irq});
         end
      join
      chk("address ack", 16'h0000, {15'h0000, a});
      fork
         mst_i.xfer(8'hff, 1'b1, q, a);
         begin
            wait_oe();
            rd(`OFS_FLAGS, 16'h0004);
            wr(`OFS_DATA, 16'h003c);
            rd(`OFS_FLAGS, 16'h0000);
         end
      join
      chk("sent byte", 16'h003c, {8'h00, q});
      rd(`OFS_STATUS, 16'h000c);
      mst_i.stop();
      repeat (8) @(posedge ref_clk);
      rd(`OFS_FLAGS, 16'h0001);
      wr(`OFS_FLAGS, 16'h0001);
      // start straight into stop, not addressed
      mst_i.start();
      mst_i.stop();
      repeat (8) @(posedge ref_clk);
      rd(`OFS_FLAGS, 16'h0000);
      rd(`OFS_STATUS, 16'h0001, 16'h0001);
      wr(`OFS_STATUS, 16'h0000);
      rd(`OFS_STATUS, 16'h0001, 16'h0001);
      wr(`OFS_STATUS, 16'h0001);
      rd(`OFS_STATUS, 16'h0000, 16'h0001);
      // foreign address, repeated start, then hold bit write
      fork
         begin
            mst_i.start();
            mst_i.xfer(8'ha6, 1'b1, q, a);
            mst_i.start();
            mst_i.xfer(8'ha4, 1'b1, q, a);
         end
         begin
            wait_oe();
            rd(`OFS_STATUS, 16'h0010, 16'h0010);
            wr(`OFS_STATUS, 16'h0080);
            rd(`OFS_FLAGS, 16'h0002);
         end
      join
      mst_i.stop();
      chk("stretch wait", 16'h0000, {15'h0000, stuck});
      summarize();
   end
endmodule
